//--- core/bbsp_map.vh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the baseband serial data port.
 * Assumes a 100 MHz APB clock; included by bare name.
 */
`ifndef BBSP_MAP_VH
`define BBSP_MAP_VH

// ***********************************************************
// Register byte offsets
// ***********************************************************
`define OFS_CTRL 8'h00
`define OFS_TX_SIG 8'h04
`define OFS_RX_SIG 8'h08
`define OFS_STATUS 8'h0c
`define OFS_TX_DATA 8'h10
`define OFS_RX_DATA 8'h14
`define OFS_RX_CMD 8'h18

// ***********************************************************
// Field positions and reset values
// ***********************************************************
`define CTRL_TX_PHASE 0
`define CTRL_CCA_INV 1
`define CTRL_CCA_ALG_LO 2
`define CTRL_RX_CLK_INV 4
`define CMD_SFD 0
`define CMD_HDR_ERR 1
`define TXDATA_VALID 8
`define CTRL_RST 5'h00
`define SIG_RST 8'h0a

// ***********************************************************
// Signalling field codes and timing
// ***********************************************************
`define SIG_1M 8'h0a
`define SIG_2M 8'h14
`define SIG_5M5 8'h37
`define SIG_11M 8'h6e
`define CLK_NS 10
`define HALF_1M_NS 500
`define HALF_2M_NS 250
`define HALF_5M5_NS 90
`define HALF_11M_NS 45
`define TX_TAIL_NS 4000
`define TX_TAIL_CYC ((`TX_TAIL_NS + `CLK_NS - 1) / `CLK_NS)
`define PRE_HDR_NS 192000
`define RX_HDR_BITS 32
`define RX_CRC_END 48

`endif

//--- core/bit_clock_gen.v
/*
 * Bit clock generator: toggles a clock every half period of pclk cycles.
 * Assumes run and stall come from pclk-domain logic.
 */
`timescale 1ns/10ps

module bit_clock_gen
(
	input wire pclk,
	input wire presetn,
	input wire run,
	input wire stall,
	input wire [7:0] half,
	output reg clk_r,
	output wire rise,
	output wire fall
);

reg [7:0] cnt_r;
wire edge_now;

// Edge falls due when the half period is used up and nothing stalls
assign edge_now = run && !stall && (cnt_r >= half - 8'h01);
assign rise = edge_now && !clk_r;
assign fall = edge_now && clk_r;

// Stopping returns the clock low so a restart begins with a clean phase
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		cnt_r <= 8'h00;
		clk_r <= 1'b0;
	end
	else if (!run)
	begin
		cnt_r <= 8'h00;
		clk_r <= 1'b0;
	end
	else if (edge_now)
	begin
		cnt_r <= 8'h00;
		clk_r <= !clk_r;
	end
	else if (!stall)
	begin
		cnt_r <= cnt_r + 8'h01;
	end
end

endmodule

//--- core/word_fifo.v
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH is a power of two equal to 2**AW.
 */
`timescale 1ns/10ps

module word_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
)
(
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_r;
reg [AW-1:0] rd_r;
reg [AW:0] cnt_r;
wire push;
wire pop;

assign in_ready = (cnt_r != DEPTH[AW:0]);
assign out_valid = (cnt_r != {(AW+1){1'b0}});
assign out_data = mem[rd_r];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

// Storage needs no reset; only the fill count defines emptiness
always @(posedge pclk)
begin
	if (push)
		mem[wr_r] <= in_data;
end

// Pointers and fill level
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		wr_r <= {AW{1'b0}};
		rd_r <= {AW{1'b0}};
		cnt_r <= {(AW+1){1'b0}};
	end
	else
	begin
		if (push)
			wr_r <= wr_r + {{(AW-1){1'b0}}, 1'b1};
		if (pop)
			rd_r <= rd_r + {{(AW-1){1'b0}}, 1'b1};
		if (push && !pop)
			cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
		else if (pop && !push)
			cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
	end
end

endmodule

//--- core/baseband_mac_serial_port.v
/*
 * Serial packet data port between a baseband processor and a MAC:
 * transmit envelope, ready and bit clock, receive bit stream with
 * frame valid, and clear channel output; APB register access.
 * Assumes pins come from outside the pclk domain; modem side inputs
 * (energy_detect, carrier_sense) are pclk-domain logic.
 */
// Decided for this implementation: the placing of the registers and the APB slave port.
// Notes on behaviour
// - Transmitter runs while the enable envelope is high, else standby.
// - Envelope rise starts the transmit machine; its fall starts shutdown.
// - Transmitter keeps running 4 us after the envelope falls.
// - Transmit payload bits arrive least significant bit first.
// - Transmit bits are sampled on the bit clock this block drives.
// - A control bit selects which clock phase captures transmit data.
// - Transmit bit clock rate follows the signalling field rate code.
// - Transmit ready rises only after preamble and header are done.
// - Clear channel output low when free, high when busy; invertible.
// - One of four assessment algorithms forms the clear channel decision.
// - Header and payload bits leave on rxd least significant bit first.
// - The first receive bit appears together with frame valid; rxd gets it at the first byte load, one pclk cycle later at the earliest.
// - Receive bit clock runs at the current packet's bit rate.
// - Receive bit clock held low over the sixteen header CRC bits.
// - Receive bit clock stays still until the start of frame is found.
// - Frame valid rises at start of frame, falls on disable or header error.
// - Receiver runs while the receive enable is high, else standby.
`timescale 1ns/10ps
`include "bbsp_map.vh"

module baseband_mac_serial_port
#(
	parameter PRE_NS = `PRE_HDR_NS,
	parameter FIFO_DEPTH = 4
)
(
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire transmit_enable_envelope,
	input wire txd,
	output wire transmit_bit_clock,
	output wire tx_ready,
	output wire tx_active,
	input wire energy_detect,
	input wire carrier_sense,
	output reg channel_clear_indication,
	input wire receive_enable_level,
	output wire rx_active,
	output wire receive_bit_clock,
	output reg rxd,
	output reg receive_frame_valid
);

// ***********************************************************
// Constants and shared functions
// ***********************************************************
localparam [1:0] T_IDLE = 2'd0;
localparam [1:0] T_HDR = 2'd1;
localparam [1:0] T_DATA = 2'd2;
localparam [1:0] T_TAIL = 2'd3;
localparam [1:0] R_IDLE = 2'd0;
localparam [1:0] R_HDR = 2'd1;
localparam [1:0] R_CRC = 2'd2;
localparam [1:0] R_PAY = 2'd3;
// Integer forms first, then cut on purpose to the counter widths
localparam integer PRE_I = PRE_NS / `CLK_NS;
localparam integer TAIL_I = `TX_TAIL_CYC;
localparam integer H1_I = `HALF_1M_NS / `CLK_NS;
localparam integer H2_I = `HALF_2M_NS / `CLK_NS;
localparam integer H55_I = `HALF_5M5_NS / `CLK_NS;
localparam integer H11_I = `HALF_11M_NS / `CLK_NS;
localparam integer HDR_I = `RX_HDR_BITS;
localparam integer CRC_I = `RX_CRC_END;
localparam [15:0] PRE_CYC = PRE_I[15:0];
localparam [15:0] TAIL_CYC = TAIL_I[15:0];
localparam [7:0] H1 = H1_I[7:0];
localparam [7:0] H2 = H2_I[7:0];
localparam [7:0] H55 = H55_I[7:0];
localparam [7:0] H11 = H11_I[7:0];
localparam [5:0] HDR_BITS = HDR_I[5:0];
localparam [5:0] CRC_END = CRC_I[5:0];

// Half bit period in pclk cycles for a signalling field code
function [7:0] half_cyc;
	input [7:0] sig;
	begin
		if (sig == `SIG_2M)
			half_cyc = H2;
		else if (sig == `SIG_5M5)
			half_cyc = H55;
		else if (sig == `SIG_11M)
			half_cyc = H11;
		else
			half_cyc = H1;
	end
endfunction

// ***********************************************************
// Pin synchronisers
// ***********************************************************
reg env_s1, env_s2, env_d;
reg txd_s1, txd_s2;
reg ren_s1, ren_s2;

// Two flops per pin; the envelope has a third flop that feeds its edge detection
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		env_s1 <= 1'b0;
		env_s2 <= 1'b0;
		env_d <= 1'b0;
		txd_s1 <= 1'b0;
		txd_s2 <= 1'b0;
		ren_s1 <= 1'b0;
		ren_s2 <= 1'b0;
	end
	else
	begin
		env_s1 <= transmit_enable_envelope;
		env_s2 <= env_s1;
		env_d <= env_s2;
		txd_s1 <= txd;
		txd_s2 <= txd_s1;
		ren_s1 <= receive_enable_level;
		ren_s2 <= ren_s1;
	end
end

wire env_rise = env_s2 && !env_d;
wire env_fall = !env_s2 && env_d;

// ***********************************************************
// Registers and APB slave
// ***********************************************************
reg [4:0] ctrl_r;
reg [7:0] tx_sig_r;
reg [7:0] rx_sig_r;
reg [7:0] rx_hold_r;
reg rx_full_r;
reg [1:0] tx_st_r;
reg [1:0] rx_st_r;
reg [31:0] rd_val;
reg map_ok;
wire [7:0] fifo_out;
wire fifo_ovalid;
wire fifo_iready;
wire wr_acc = psel && penable && pwrite;
wire rd_acc = psel && penable && !pwrite;
wire rx_load;
wire sfd_cmd = wr_acc && (paddr == `OFS_RX_CMD) && pwdata[`CMD_SFD];
wire herr_cmd = wr_acc && (paddr == `OFS_RX_CMD) && pwdata[`CMD_HDR_ERR];
// Pop only what the setup cycle showed, so a read seen empty never eats a late byte
wire tx_pop = rd_acc && (paddr == `OFS_TX_DATA) && prdata[`TXDATA_VALID];

assign pready = 1'b1;
assign pslverr = psel && penable && !map_ok;

// Address decode and read mux
always @*
begin
	rd_val = 32'h0000_0000;
	map_ok = 1'b1;
	if (paddr == `OFS_CTRL)
		rd_val = {27'h0, ctrl_r};
	else if (paddr == `OFS_TX_SIG)
		rd_val = {24'h0, tx_sig_r};
	else if (paddr == `OFS_RX_SIG)
		rd_val = {24'h0, rx_sig_r};
	else if (paddr == `OFS_STATUS)
		rd_val = {23'h0, rx_full_r, fifo_ovalid, fifo_iready, receive_frame_valid,
			tx_ready, rx_st_r, tx_st_r};
	else if (paddr == `OFS_TX_DATA)
		rd_val = {23'h0, fifo_ovalid, fifo_out};
	else if (paddr == `OFS_RX_DATA || paddr == `OFS_RX_CMD)
		rd_val = 32'h0000_0000;
	else
		map_ok = 1'b0;
end

// Read data is caught in the setup cycle so prdata comes from a flop
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		prdata <= 32'h0000_0000;
	else if (psel && !penable && !pwrite)
		prdata <= rd_val;
end

// Writable registers; the receive byte holder is set by software
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		ctrl_r <= `CTRL_RST;
		tx_sig_r <= `SIG_RST;
		rx_sig_r <= `SIG_RST;
		rx_hold_r <= 8'h00;
		rx_full_r <= 1'b0;
	end
	else
	begin
		if (wr_acc && paddr == `OFS_CTRL)
			ctrl_r <= pwdata[4:0];
		if (wr_acc && paddr == `OFS_TX_SIG)
			tx_sig_r <= pwdata[7:0];
		if (wr_acc && paddr == `OFS_RX_SIG)
			rx_sig_r <= pwdata[7:0];
		// A new byte written while one is taken wins over the take
		if (wr_acc && paddr == `OFS_RX_DATA && (!rx_full_r || rx_load))
		begin
			rx_hold_r <= pwdata[7:0];
			rx_full_r <= 1'b1;
		end
		else if (rx_load)
			rx_full_r <= 1'b0;
	end
end

// ***********************************************************
// Transmit path
// ***********************************************************
reg [15:0] tx_cnt_r;
reg [7:0] tx_sh_r;
reg [2:0] tx_bit_r;
reg tx_pend_r;
reg [7:0] tx_byte_r;
wire tclk;
wire t_rise, t_fall, t_cap;
// A finished byte the FIFO cannot take freezes the bit clock
wire tx_stall = tx_pend_r && !fifo_iready;
wire tx_run = (tx_st_r == T_DATA) || (tx_st_r == T_TAIL);

assign tx_active = (tx_st_r != T_IDLE);
assign tx_ready = (tx_st_r == T_DATA);
assign transmit_bit_clock = tclk;
assign t_cap = ctrl_r[`CTRL_TX_PHASE] ? t_fall : t_rise;

bit_clock_gen u_tx_clk
(
	.pclk(pclk),
	.presetn(presetn),
	.run(tx_run),
	.stall(tx_stall),
	.half(half_cyc(tx_sig_r)),
	.clk_r(tclk),
	.rise(t_rise),
	.fall(t_fall)
);

// Transmit sequencer: header time, data, then the shutdown tail
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		tx_st_r <= T_IDLE;
		tx_cnt_r <= 16'h0000;
	end
	else
	begin
		case (tx_st_r)
			T_IDLE:
			begin
				tx_cnt_r <= 16'h0000;
				if (env_rise)
					tx_st_r <= T_HDR;
			end
			T_HDR:
			begin
				tx_cnt_r <= tx_cnt_r + 16'h0001;
				if (env_fall)
				begin
					tx_st_r <= T_TAIL;
					tx_cnt_r <= 16'h0000;
				end
				else if (tx_cnt_r >= PRE_CYC - 16'h0001)
					tx_st_r <= T_DATA;
			end
			T_DATA:
			begin
				if (env_fall)
				begin
					tx_st_r <= T_TAIL;
					tx_cnt_r <= 16'h0000;
				end
			end
			default:
			begin
				tx_cnt_r <= tx_cnt_r + 16'h0001;
				if (env_rise)
				begin
					tx_st_r <= T_HDR;
					tx_cnt_r <= 16'h0000;
				end
				else if (tx_cnt_r >= TAIL_CYC - 16'h0001)
					tx_st_r <= T_IDLE;
			end
		endcase
	end
end

// Bit capture; the last bit may land after the envelope has dropped
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		tx_sh_r <= 8'h00;
		tx_bit_r <= 3'd0;
		tx_pend_r <= 1'b0;
		tx_byte_r <= 8'h00;
	end
	else
	begin
		if (tx_pend_r && fifo_iready)
			tx_pend_r <= 1'b0;
		if (!tx_run)
			tx_bit_r <= 3'd0;
		// sample on own clock
		// A byte begun before the envelope fell may finish in the tail; none starts there
		else if (t_cap && (tx_ready || tx_bit_r != 3'd0))
		begin
			tx_sh_r <= {txd_s2, tx_sh_r[7:1]};
			tx_bit_r <= tx_bit_r + 3'd1;
			if (tx_bit_r == 3'd7)
			begin
				tx_byte_r <= {txd_s2, tx_sh_r[7:1]};
				tx_pend_r <= 1'b1;
			end
		end
	end
end

// Payload bytes wait here until software drains them
word_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(2)) u_tx_fifo
(
	.pclk(pclk),
	.presetn(presetn),
	.in_data(tx_byte_r),
	.in_valid(tx_pend_r),
	.in_ready(fifo_iready),
	.out_data(fifo_out),
	.out_valid(fifo_ovalid),
	.out_ready(tx_pop)
);

// ***********************************************************
// Clear channel assessment
// ***********************************************************
reg busy;

always @*
begin
	case (ctrl_r[`CTRL_CCA_ALG_LO+1:`CTRL_CCA_ALG_LO])
		2'd0: busy = energy_detect;
		2'd1: busy = carrier_sense;
		2'd2: busy = energy_detect && carrier_sense;
		default: busy = energy_detect || carrier_sense;
	endcase
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		channel_clear_indication <= 1'b0;
	else
		channel_clear_indication <= busy ^ ctrl_r[`CTRL_CCA_INV];
end

// ***********************************************************
// Receive path
// ***********************************************************
reg [5:0] rx_cnt_r;
reg [7:0] rx_sh_r;
reg rx_need_r;
wire rclk, r_fall;
wire rx_run = (rx_st_r != R_IDLE);
wire [5:0] rx_cnt_n = rx_cnt_r + 6'd1;
wire rx_gate = (rx_st_r == R_HDR) || (rx_st_r == R_PAY);

assign rx_active = ren_s2;
assign rx_load = rx_need_r && rx_full_r && rx_run;
assign receive_bit_clock = rx_gate && (rclk ^ ctrl_r[`CTRL_RX_CLK_INV]);

bit_clock_gen u_rx_clk
(
	.pclk(pclk),
	.presetn(presetn),
	.run(rx_run),
	.stall(rx_need_r),
	.half(half_cyc(rx_sig_r)),
	.clk_r(rclk),
	.rise(),
	.fall(r_fall)
);

// Receive framing; each bit spans one clock period, falling edge to
// falling edge, so the rising edge sits in the middle of the bit
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		rx_st_r <= R_IDLE;
		rx_cnt_r <= 6'd0;
		rx_sh_r <= 8'h00;
		rx_need_r <= 1'b0;
		rxd <= 1'b0;
		receive_frame_valid <= 1'b0;
	end
	else if (rx_run && (!ren_s2 || herr_cmd))
	begin
		rx_st_r <= R_IDLE;
		rx_need_r <= 1'b0;
		rxd <= 1'b0;
		receive_frame_valid <= 1'b0;
	end
	else
	begin
		case (rx_st_r)
			R_IDLE:
			begin
				rx_cnt_r <= 6'd0;
				if (sfd_cmd && ren_s2)
				begin
					rx_st_r <= R_HDR;
					receive_frame_valid <= 1'b1;
					rx_need_r <= 1'b1;
				end
			end
			R_CRC:
			begin
				if (r_fall)
				begin
					rx_cnt_r <= rx_cnt_n;
					if (rx_cnt_n == CRC_END)
					begin
						rx_st_r <= R_PAY;
						rx_need_r <= 1'b1;
					end
				end
			end
			default:
			begin
				if (rx_load)
				begin
					rx_sh_r <= rx_hold_r;
					rxd <= rx_hold_r[0];
					rx_need_r <= 1'b0;
				end
				else if (r_fall)
				begin
					rx_cnt_r <= rx_cnt_n;
					if (rx_st_r == R_HDR && rx_cnt_n == HDR_BITS)
					begin
						rx_st_r <= R_CRC;
						rxd <= 1'b0;
					end
					else if (rx_cnt_n[2:0] == 3'd0)
						rx_need_r <= 1'b1;
					else
					begin
						rxd <= rx_sh_r[1];
						rx_sh_r <= {1'b0, rx_sh_r[7:1]};
					end
				end
			end
		endcase
	end
end

endmodule

//--- tb/bbsp_pin_check_assertions.sv
/* Pin checker of the serial data port.
   Assumes binding to the top module, which hands on PRE_NS. */
`timescale 1ns/10ps
module bbsp_pin_check
#(
	parameter PRE_NS = 200
)
(
	input wire pclk,
	input wire presetn,
	input wire transmit_enable_envelope,
	input wire tx_ready,
	input wire tx_active,
	input wire transmit_bit_clock,
	input wire receive_enable_level,
	input wire rx_active,
	input wire receive_bit_clock,
	input wire receive_frame_valid
);
	localparam int PRE_CYC = PRE_NS / 10;
	logic [15:0] lo_r;
	logic [15:0] act_r;
	logic [7:0] rise_r;
	logic rck_r;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ******************************
	// Helper counters
	// ******************************
	// Saturating envelope-low count; receive clock rises within a frame
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lo_r <= 16'h0000;
			act_r <= 16'h0000;
			rise_r <= 8'h00;
			rck_r <= 1'b0;
		end
		else
		begin
			lo_r <= transmit_enable_envelope ? 16'h0000 : lo_r + {15'h0000, lo_r != 16'hffff};
			act_r <= tx_active ? act_r + 16'h0001 : 16'h0000;
			rise_r <= receive_frame_valid ? rise_r + {7'h00, receive_bit_clock & ~rck_r} : 8'h00;
			rck_r <= receive_bit_clock;
		end
	end
	sequence s_rx_off;
		!receive_enable_level [*3];
	endsequence
	sequence s_crc_gap;
		!receive_bit_clock [*8];
	endsequence
	a_tx_standby: assert property (!tx_active && !$past(tx_active) |->
		!tx_ready && !transmit_bit_clock) else $error("tx outputs live in standby");
	a_tail_time: assert property ($fell(tx_active) |->
		lo_r >= 400 && lo_r <= 406) else $error("tail length wrong");
	a_ready_late: assert property ($rose(tx_ready) |->
		act_r >= PRE_CYC - 2 && act_r <= PRE_CYC + 2) else $error("tx ready timing");
	a_receive_bit_clock_still: assert property (!receive_frame_valid |->
		!receive_bit_clock) else $error("rx clock outside frame");
	a_crc_quiet: assert property ($fell(receive_bit_clock) && rise_r == 8'd32 |->
		s_crc_gap) else $error("rx clock runs over crc");
	a_rx_standby: assert property (s_rx_off |-> !rx_active)
		else $error("receiver active while disabled");
	a_fv_drop: assert property (!rx_active ##1 !rx_active |-> !receive_frame_valid)
		else $error("frame valid without enable");
	a_fv_start: assert property ($rose(receive_frame_valid) |->
		rx_active && !receive_bit_clock) else $error("frame start misaligned");
endmodule
bind baseband_mac_serial_port bbsp_pin_check #(.PRE_NS(PRE_NS)) i_pin_check (.pclk, .presetn,
	.transmit_enable_envelope, .tx_ready, .tx_active, .transmit_bit_clock,
	.receive_enable_level, .rx_active, .receive_bit_clock, .receive_frame_valid);

//--- tb/mac_partner.sv
/* MAC model on the far side of the serial data port.
   Assumes pclk-domain port outputs; one five-byte burst per go pulse. */
`timescale 1ns/10ps
module mac_partner
(
	input wire pclk,
	input wire presetn,
	input wire go,
	input wire phase,
	input wire [39:0] tx_bits,
	input wire transmit_bit_clock,
	input wire tx_ready,
	input wire receive_bit_clock,
	input wire rxd,
	input wire receive_frame_valid,
	output logic transmit_enable_envelope,
	output wire txd
);
	logic [7:0] rx_q[$];
	logic [7:0] acc_r;
	logic [5:0] nb_r;
	logic [2:0] rb_r;
	logic tck_r, rck_r, adv_r, tog_r;
	wire cap = phase ? (tck_r & ~transmit_bit_clock) : (~tck_r & transmit_bit_clock);
	wire opp = (tck_r ^ transmit_bit_clock) & ~cap;
	// least bit first
	// Released line toggles so a stale bit never looks valid
	assign txd = (transmit_enable_envelope && tx_ready) ? tx_bits[nb_r] : tog_r;
	// Burst sender and receive collector
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			transmit_enable_envelope <= 1'b0;
			{nb_r, rb_r, acc_r, tck_r, rck_r, adv_r, tog_r} <= 21'h0;
		end
		else
		begin
			tck_r <= transmit_bit_clock;
			rck_r <= receive_bit_clock;
			tog_r <= ~tog_r;
			if (go)
			begin
				transmit_enable_envelope <= 1'b1;
				nb_r <= 6'd0;
				adv_r <= 1'b0;
			end
			else if (transmit_enable_envelope && tx_ready && cap)
			begin
				adv_r <= 1'b1;
				transmit_enable_envelope <= (nb_r != 6'd39);
			end
			else if (adv_r && opp)
			begin
				nb_r <= nb_r + 6'd1;
				adv_r <= 1'b0;
			end
			if (!receive_frame_valid)
				rb_r <= 3'd0;
			else if (receive_bit_clock && !rck_r)
			begin
				acc_r <= {rxd, acc_r[7:1]};
				rb_r <= rb_r + 3'd1;
				if (rb_r == 3'd7)
					rx_q.push_back({rxd, acc_r[7:1]});
			end
		end
	end
endmodule

//--- tb/baseband_mac_serial_port_test.sv
/* Self-checking bench of the serial data port with a MAC model.
   Assumes the port's register map header and a 100 MHz pclk. */
`timescale 1ns/10ps
`include "bbsp_map.vh"
`define CHK(got, want) \
	begin \
		samples_checked++; \
		if ((got) !== (want)) \
		begin \
			fails++; \
			$display("FAIL %0t got %h exp %h", $time, got, want); \
		end \
	end
module baseband_mac_serial_port_test;
	logic pclk, presetn, psel, penable, pwrite, energy_detect, carrier_sense;
	logic receive_enable_level, go, phase, sl, busy;
	logic [7:0] paddr, e;
	logic [31:0] pwdata, r;
	logic [39:0] tx_bits;
	logic [15:0] rnd;
	logic [7:0] exp_q[$];
	wire [31:0] prdata;
	wire pready, pslverr, transmit_enable_envelope, txd, transmit_bit_clock, tx_ready, tx_active;
	wire channel_clear_indication, rx_active, receive_bit_clock, rxd, receive_frame_valid;
	int fails, samples_checked, cycles;
	time t1, t2, tw;
	baseband_mac_serial_port #(.PRE_NS(200)) i_baseband_mac_serial_port (.pclk, .presetn,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.transmit_enable_envelope, .txd, .transmit_bit_clock, .tx_ready, .tx_active,
		.energy_detect, .carrier_sense, .channel_clear_indication, .receive_enable_level,
		.rx_active, .receive_bit_clock, .rxd, .receive_frame_valid);
	mac_partner i_mac_partner (.pclk, .presetn, .go, .phase, .tx_bits, .transmit_bit_clock,
		.tx_ready, .receive_bit_clock, .rxd, .receive_frame_valid, .transmit_enable_envelope, .txd);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// One APB transfer; waits for pready, never assumes a count
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		sl = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task tally_and_finish();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Hang guard, far above the few thousand cycles needed
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	initial
	begin
		{psel, penable, pwrite, energy_detect, carrier_sense, receive_enable_level} = 6'h00;
		{go, phase, paddr, pwdata, tx_bits, presetn} = 83'h0;
		{fails, samples_checked, cycles, rnd} = {32'h0, 32'h0, 32'h0, 16'ha831};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, then an unmapped place
		apb(1'b0, `OFS_CTRL, 32'h0);
		`CHK(r, 32'h0)
		apb(1'b0, `OFS_TX_SIG, 32'h0);
		`CHK(r, 32'h0a)
		apb(1'b0, 8'h1c, 32'h0);
		`CHK({sl, r}, {1'b1, 32'h0})
		// Every assessment mode, both polarities, random modem levels
		for (int k = 0; k < 16; k++)
		begin
			apb(1'b1, `OFS_CTRL, {28'h0, k[1:0], k[2], 1'b0});
			rnd = lfsr(rnd);
			energy_detect <= rnd[0];
			carrier_sense <= rnd[1];
			busy = k[1] ? (k[0] ? rnd[0] | rnd[1] : rnd[0] & rnd[1]) : (k[0] ? rnd[1] : rnd[0]);
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			`CHK(channel_clear_indication, busy ^ k[2])
		end
		// Five-byte bursts on both capture edges and two rates; fifth byte must wait
		for (int p = 0; p < 2; p++)
		begin
			apb(1'b1, `OFS_TX_SIG, {24'h0, p ? `SIG_5M5 : `SIG_11M});
			apb(1'b1, `OFS_CTRL, {31'h0, p[0]});
			for (int i = 0; i < 5; i++)
			begin
				rnd = lfsr(rnd);
				tx_bits[i*8 +: 8] <= rnd[7:0];
				exp_q.push_back(rnd[7:0]);
			end
			phase <= p[0];
			go <= 1'b1;
			@(posedge pclk);
			go <= 1'b0;
			wait (tx_ready === 1'b1);
			@(posedge transmit_bit_clock);
			t1 = $time;
			@(posedge transmit_bit_clock);
			t2 = $time;
			tw = 2 * (p ? `HALF_5M5_NS / `CLK_NS : `HALF_11M_NS / `CLK_NS) * `CLK_NS;
			`CHK(t2 - t1, tw)
			do apb(1'b0, `OFS_STATUS, 32'h0); while (r[6] !== 1'b0);
			repeat (100) @(posedge pclk);
			apb(1'b0, `OFS_STATUS, 32'h0);
			`CHK(r[7:6], 2'b10)
			while (exp_q.size() > 0)
			begin
				apb(1'b0, `OFS_TX_DATA, 32'h0);
				if (r[8] === 1'b1)
				begin
					e = exp_q.pop_front();
					`CHK(r[7:0], e)
				end
			end
			while (tx_active !== 1'b0)
				@(posedge pclk);
			@(negedge pclk);
			`CHK({tx_ready, transmit_bit_clock}, 2'b00)
		end
		// Four header and two payload bytes out on the receive line
		apb(1'b1, `OFS_RX_SIG, {24'h0, `SIG_2M});
		receive_enable_level <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			exp_q.push_back(rnd[7:0]);
			do apb(1'b0, `OFS_STATUS, 32'h0); while (r[8] !== 1'b0);
			apb(1'b1, `OFS_RX_DATA, {24'h0, rnd[7:0]});
			if (i == 0)
				apb(1'b1, `OFS_RX_CMD, 32'h1);
			// Two rises inside the first byte give one bit period
			if (i == 1)
			begin
				@(posedge receive_bit_clock) t1 = $time;
				@(posedge receive_bit_clock) t2 = $time;
				tw = 2 * (`HALF_2M_NS / `CLK_NS) * `CLK_NS;
				`CHK(t2 - t1, tw)
			end
		end
		`CHK(receive_frame_valid, 1'b1)
		while (i_mac_partner.rx_q.size() < 6)
			@(posedge pclk);
		foreach (exp_q[i])
			`CHK(i_mac_partner.rx_q[i], exp_q[i])
		receive_enable_level <= 1'b0;
		repeat (4) @(negedge pclk);
		`CHK({rx_active, receive_frame_valid, receive_bit_clock}, 3'b000)
		// A header error cuts a frame short
		@(posedge pclk);
		receive_enable_level <= 1'b1;
		apb(1'b1, `OFS_RX_DATA, 32'h5a);
		apb(1'b1, `OFS_RX_CMD, 32'h1);
		repeat (2) @(negedge pclk);
		`CHK(receive_frame_valid, 1'b1)
		apb(1'b1, `OFS_RX_CMD, 32'h2);
		repeat (2) @(negedge pclk);
		`CHK(receive_frame_valid, 1'b0)
		tally_and_finish();
	end
endmodule
